// ==== verilog/nfi_params.svh ====
// register offsets, field positions and reset values of the interrupt unit
// assumes byte addressing on an aligned 32-bit register bus
`ifndef NFI_PARAMS_SVH
`define NFI_PARAMS_SVH
// printed offsets are register indices; byte address is four times these
`define NFI_IDX_FLAGS0 6'h06
`define NFI_IDX_FLAGS1 6'h07
`define NFI_IDX_EN0 6'h08
`define NFI_IDX_EN1 6'h09
`define NFI_IDX_CMD 6'h0A
`define NFI_IDX_PIN 6'h0B
`define NFI_SET_BIT 7
`define NFI_F0_HIGH 6
`define NFI_F0_LOW 5
`define NFI_F0_CMD 4
`define NFI_F0_TX 3
`define NFI_F0_RX 2
`define NFI_F0_ERR 1
`define NFI_F0_SOF 0
`define NFI_F1_SUM 6
`define NFI_F1_CARD 5
`define NFI_EN0_INV 7
`define NFI_EN1_DRIVE 7
`define NFI_EN1_PIN 6
`define NFI_RST_BYTE 8'h00
`define NFI_CMD_IDLE 4'h0
`define NFI_CMD_LAST 4'h7
`define NFI_RESP_OKAY 2'h0
`define NFI_RESP_DECERR 2'h3
`endif

// ==== verilog/nfi_pkg.sv ====
// types shared by the interrupt unit
// assumes nfi_params.svh for numeric constants
`default_nettype none
package nfi_pkg;
  typedef struct packed {
    logic fifo_high_level_live;
    logic fifo_low_level_live;
    logic transmit_done;
    logic receive_done;
    logic fifo_write_while_busy_error;
    logic fifo_overflow_error;
    logic protocol_error;
    logic empty_transmit_error;
    logic integrity_error;
    logic frame_start;
    logic card_detected;
    logic [4:0] timer_underflow;
  } nfi_events_type;
  typedef struct packed {
    logic [5:0] addr;
    logic [31:0] data;
  } nfi_access_type;
  typedef enum logic [2:0] {
    NFI_IDLE = 3'b001,
    NFI_WRESP = 3'b010,
    NFI_RRESP = 3'b100
  } nfi_bus_state_type;
endpackage
`default_nettype wire

// ==== verilog/nfi_irq_unit.sv ====
// interrupt request unit: flag registers, enables, request pin stage
// assumes an axi4-lite master on aclk and event pulses synchronous to aclk
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "nfi_params.svh"

// Functional notes
// - first flags: bit7 chooses set or clear
// - second flags same, summary not writable
// - latch fifo high level rising edge
// - latch fifo low level rising edge
// - command ending by itself (command_self_end) returning to idle sets finished
// - undefined command goes idle, sets finished
// - host writing idle sets no flag
// - transmit done sets bit 3
// - receive end sets bit 2 regardless
// - listed errors rising set error flag
// - frame start sets bit 0
// - enabled active flag sets summary flag
// - card detection sets bit 5
// - timer underflows set bits 0 to 4
// - first enable bit7 inverts pin
// - first enables gate first flags
// - first flags at 06h reset 00h
// - second enable bit6 gates pin
// - second enable bit7 push-pull else open-drain
// - second enables gate card and timers
module nfi_irq_unit #(
  parameter int CMD_W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire nfi_pkg::nfi_events_type events,
  input wire logic command_self_end,
  output logic [CMD_W-1:0] command_code,
  output logic request_pin_out,
  output logic request_pin_oe_n
);
  import nfi_pkg::*;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [6:0] flags0_q, flags0_d;
  logic [5:0] flags1_q, flags1_d;
  logic summary_q, summary_d;
  logic [7:0] en0_q, en1_q;
  logic [CMD_W-1:0] cmd_q, cmd_d;
  logic high_live_q, low_live_q, err_any_q;
  logic pin_out_q, pin_oe_n_q;
  nfi_bus_state_type state_q;
  logic aw_held_q, w_held_q;
  logic [5:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic w_lane0_q;
  logic [31:0] rdata_q;
  logic [1:0] bresp_q, rresp_q;
  logic awready_q, wready_q, arready_q;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire logic aw_fire = s_axi_awvalid && awready_q;
  wire logic w_fire = s_axi_wvalid && wready_q;
  wire logic have_aw = aw_held_q || aw_fire;
  wire logic have_w = w_held_q || w_fire;
  wire logic [5:0] wr_idx = aw_held_q ? aw_addr_q : s_axi_awaddr[7:2];
  wire logic [31:0] wr_dat = w_held_q ? w_data_q : s_axi_wdata;
  wire logic wr_lane0 = w_held_q ? w_lane0_q : s_axi_wstrb[0];
  wire logic wr_go = (state_q == NFI_IDLE) && have_aw && have_w && clk_en;
  wire logic wr_byte = wr_go && wr_lane0;
  wire logic wr_f0 = wr_byte && (wr_idx == `NFI_IDX_FLAGS0);
  wire logic wr_f1 = wr_byte && (wr_idx == `NFI_IDX_FLAGS1);
  wire logic wr_e0 = wr_byte && (wr_idx == `NFI_IDX_EN0);
  wire logic wr_e1 = wr_byte && (wr_idx == `NFI_IDX_EN1);
  wire logic wr_cmd = wr_byte && (wr_idx == `NFI_IDX_CMD);
  wire logic wr_hit = (wr_idx >= `NFI_IDX_FLAGS0) && (wr_idx <= `NFI_IDX_PIN);
  wire logic rd_go = (state_q == NFI_IDLE) && s_axi_arvalid && arready_q
    && clk_en && !wr_go;
  wire logic [5:0] rd_idx = s_axi_araddr[7:2];
  wire logic set_mode = wr_dat[`NFI_SET_BIT];
  wire logic [7:0] wr_byte_val = wr_dat[7:0];

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  wire logic err_any = events.fifo_write_while_busy_error
    || events.fifo_overflow_error || events.protocol_error
    || events.empty_transmit_error || events.integrity_error;
  wire logic cmd_defined = (wr_dat[CMD_W-1:0] <= CMD_W'(`NFI_CMD_LAST));
  wire logic cmd_bad = wr_cmd && !cmd_defined;
  wire logic cmd_self = command_self_end && (cmd_q != CMD_W'(`NFI_CMD_IDLE))
    && !wr_cmd;
  logic [6:0] hw_set0;
  logic [5:0] hw_set1;
  always_comb begin
    hw_set0 = 7'h00;
    hw_set0[`NFI_F0_HIGH] = events.fifo_high_level_live && !high_live_q;
    hw_set0[`NFI_F0_LOW] = events.fifo_low_level_live && !low_live_q;
    // host writing idle is not a self end
    hw_set0[`NFI_F0_CMD] = cmd_self || cmd_bad;
    hw_set0[`NFI_F0_TX] = events.transmit_done;
    hw_set0[`NFI_F0_RX] = events.receive_done;
    hw_set0[`NFI_F0_ERR] = err_any && !err_any_q;
    hw_set0[`NFI_F0_SOF] = events.frame_start;
    hw_set1 = {events.card_detected, events.timer_underflow};
  end

  // ----------------------------------------------------------------
  // flag update: software set/clear, hardware set wins
  // ----------------------------------------------------------------
  wire logic [6:0] sw0 = wr_f0 ? wr_byte_val[6:0] : 7'h00;
  wire logic [5:0] sw1 = wr_f1 ? wr_byte_val[5:0] : 6'h00;
  always_comb begin
    flags0_d = set_mode ? (flags0_q | sw0) : (flags0_q & ~sw0);
    flags0_d = flags0_d | hw_set0;
    flags1_d = set_mode ? (flags1_q | sw1) : (flags1_q & ~sw1);
    flags1_d = flags1_d | hw_set1;
  end
  wire logic [6:0] gated0 = flags0_d & en0_q[6:0];
  wire logic [5:0] gated1 = flags1_d & en1_q[5:0];
  // summary follows the enabled flags and is not software writable
  always_comb begin
    summary_d = (|gated0) || (|gated1);
  end
  always_comb begin
    cmd_d = cmd_q;
    if (wr_cmd) begin
      cmd_d = cmd_defined ? wr_dat[CMD_W-1:0] : CMD_W'(`NFI_CMD_IDLE);
    end else if (cmd_self) begin
      cmd_d = CMD_W'(`NFI_CMD_IDLE);
    end
  end
  wire logic pin_active = (summary_q && en1_q[`NFI_EN1_PIN]);
  wire logic pin_level = pin_active ^ en0_q[`NFI_EN0_INV];
  // open drain releases the pin when the level is high
  wire logic pin_oe_n_d = en1_q[`NFI_EN1_DRIVE] ? 1'b0 : pin_level;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = `NFI_RST_BYTE;
    unique case (rd_idx)
      `NFI_IDX_FLAGS0: rd_byte = {1'b0, flags0_q};
      `NFI_IDX_FLAGS1: rd_byte = {1'b0, summary_q, flags1_q};
      `NFI_IDX_EN0: rd_byte = en0_q;
      `NFI_IDX_EN1: rd_byte = en1_q;
      `NFI_IDX_CMD: rd_byte = 8'(cmd_q);
      `NFI_IDX_PIN: rd_byte = {7'h00, pin_out_q};
      default: rd_byte = `NFI_RST_BYTE;
    endcase
  end
  wire logic rd_hit = (rd_idx >= `NFI_IDX_FLAGS0) && (rd_idx <= `NFI_IDX_PIN);

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags0_q <= 7'h00;
      flags1_q <= 6'h00;
      summary_q <= 1'b0;
      en0_q <= `NFI_RST_BYTE;
      en1_q <= `NFI_RST_BYTE;
      cmd_q <= CMD_W'(`NFI_CMD_IDLE);
      // take the live levels so one already high at release is no edge
      high_live_q <= events.fifo_high_level_live;
      low_live_q <= events.fifo_low_level_live;
      err_any_q <= err_any;
      pin_out_q <= 1'b0;
      pin_oe_n_q <= 1'b1;
    end else if (clk_en) begin
      flags0_q <= flags0_d;
      flags1_q <= flags1_d;
      summary_q <= summary_d;
      cmd_q <= cmd_d;
      high_live_q <= events.fifo_high_level_live;
      low_live_q <= events.fifo_low_level_live;
      err_any_q <= err_any;
      pin_out_q <= pin_level;
      pin_oe_n_q <= pin_oe_n_d;
      if (wr_e0) en0_q <= wr_byte_val;
      if (wr_e1) en1_q <= wr_byte_val;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= NFI_IDLE;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 6'h00;
      w_data_q <= 32'h00000000;
      w_lane0_q <= 1'b0;
      rdata_q <= 32'h00000000;
      bresp_q <= `NFI_RESP_OKAY;
      rresp_q <= `NFI_RESP_OKAY;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
    end else if (clk_en) begin
      unique case (state_q)
        NFI_IDLE: begin
          if (aw_fire) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr[7:2];
          end
          if (w_fire) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_lane0_q <= s_axi_wstrb[0];
          end
          awready_q <= !have_aw;
          wready_q <= !have_w;
          arready_q <= 1'b1;
          if (wr_go) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            arready_q <= 1'b0;
            bresp_q <= wr_hit ? `NFI_RESP_OKAY : `NFI_RESP_DECERR;
            state_q <= NFI_WRESP;
          end else if (rd_go) begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            arready_q <= 1'b0;
            rdata_q <= {24'h000000, rd_byte};
            rresp_q <= rd_hit ? `NFI_RESP_OKAY : `NFI_RESP_DECERR;
            state_q <= NFI_RRESP;
          end
        end
        NFI_WRESP: begin
          if (s_axi_bready) begin
            state_q <= NFI_IDLE;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            arready_q <= 1'b1;
          end
        end
        NFI_RRESP: begin
          if (s_axi_rready) begin
            state_q <= NFI_IDLE;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            arready_q <= 1'b1;
          end
        end
      endcase
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_arready = arready_q;
  assign s_axi_bvalid = (state_q == NFI_WRESP);
  assign s_axi_rvalid = (state_q == NFI_RRESP);
  assign s_axi_bresp = bresp_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign command_code = cmd_q;
  assign request_pin_out = pin_out_q;
  assign request_pin_oe_n = pin_oe_n_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_high_rise;
    clk_en && events.fifo_high_level_live && !high_live_q;
  endsequence
  sequence s_low_rise;
    clk_en && events.fifo_low_level_live && !low_live_q;
  endsequence
  sequence s_err_rise;
    clk_en && err_any && !err_any_q;
  endsequence
  // an enabled flag in the next state of either flag register
  sequence s_enabled_pending;
    clk_en && ((|(flags0_d & en0_q[6:0])) || (|(flags1_d & en1_q[5:0])));
  endsequence
  sequence s_nothing_enabled;
    clk_en && !(|(flags0_d & en0_q[6:0])) && !(|(flags1_d & en1_q[5:0]));
  endsequence
  // hardware events latch one cycle after they are seen
  chk_high_latch: assert property (s_high_rise |=> flags0_q[6])
    else $error("high level event not latched");
  chk_low_latch: assert property (s_low_rise |=> flags0_q[5])
    else $error("low level event not latched");
  chk_set_write: assert property (wr_f0 && set_mode
      |=> (flags0_q & $past(wr_byte_val[6:0])) == $past(wr_byte_val[6:0]))
    else $error("set write did not set flags");
  chk_clear_write: assert property (wr_f1 && !set_mode && !(|hw_set1)
      |=> (flags1_q & $past(wr_byte_val[5:0])) == 6'h00)
    else $error("clear write did not clear flags");
  chk_cmd_self: assert property (clk_en && cmd_self
      |=> cmd_q == CMD_W'(`NFI_CMD_IDLE) && flags0_q[`NFI_F0_CMD])
    else $error("self ended command not reported");
  chk_bad_cmd: assert property (cmd_bad
      |=> cmd_q == CMD_W'(`NFI_CMD_IDLE) && flags0_q[`NFI_F0_CMD])
    else $error("undefined command not handled");
  chk_host_idle: assert property (wr_cmd && !flags0_q[`NFI_F0_CMD]
      && wr_dat[CMD_W-1:0] == CMD_W'(`NFI_CMD_IDLE)
      |=> !flags0_q[`NFI_F0_CMD])
    else $error("host idle set finished flag");
  chk_tx_done: assert property (clk_en && events.transmit_done
      |=> flags0_q[`NFI_F0_TX])
    else $error("transmit done flag missing");
  chk_rx_done: assert property (clk_en && events.receive_done
      |=> flags0_q[`NFI_F0_RX])
    else $error("receive done flag missing");
  chk_err_set: assert property (s_err_rise |=> flags0_q[`NFI_F0_ERR])
    else $error("error event flag missing");
  chk_sof_set: assert property (clk_en && events.frame_start
      |=> flags0_q[`NFI_F0_SOF])
    else $error("frame start flag missing");
  chk_card_set: assert property (clk_en && events.card_detected
      |=> flags1_q[`NFI_F1_CARD])
    else $error("card detected flag missing");
  chk_timer_set: assert property (clk_en && (|events.timer_underflow)
      |=> (flags1_q[4:0] & $past(events.timer_underflow))
      == $past(events.timer_underflow))
    else $error("timer underflow flag missing");
  chk_summary: assert property (s_enabled_pending |=> summary_q)
    else $error("summary flag not raised");
  chk_summary_gate: assert property (s_nothing_enabled |=> !summary_q)
    else $error("summary flag raised with nothing enabled");
  // request pin stage, then clock enable freeze, unmapped read and reset checks
  chk_pin_level: assert property (clk_en |=> pin_out_q ==
      ($past(summary_q && en1_q[`NFI_EN1_PIN]) ^ $past(en0_q[`NFI_EN0_INV])))
    else $error("request pin level wrong");
  chk_open_drain: assert property (!en1_q[`NFI_EN1_DRIVE] && pin_out_q
      |-> pin_oe_n_q || $past(en1_q[`NFI_EN1_DRIVE]))
    else $error("open drain drove high");
  chk_drain_level: assert property (clk_en && !en1_q[`NFI_EN1_DRIVE]
      |=> pin_oe_n_q == pin_out_q)
    else $error("open drain enable does not follow level");
  chk_push_pull: assert property (clk_en && en1_q[`NFI_EN1_DRIVE]
      |=> !pin_oe_n_q)
    else $error("push pull pin not driven");
  chk_freeze: assert property (!clk_en |=> $stable(flags0_q)
      && $stable(flags1_q) && $stable(cmd_q))
    else $error("state moved while clock enable low");
  chk_unmapped_read: assert property (rd_go && !rd_hit
      |=> s_axi_rresp == `NFI_RESP_DECERR && s_axi_rdata == 32'h00000000)
    else $error("unmapped read not refused");
  chk_reset_zero: assert property ($rose(aresetn)
      |-> flags0_q == 7'h00)
    else $error("first flags not zero after reset");
endmodule
`default_nettype wire

// ==== verif/nfi_host_pin.sv ====
// host controller side of the interrupt request pin
// assumes a pull-up on the wire while the unit releases it
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// pin sampler
// ----------------------------------------
module nfi_host_pin (
  input wire logic aclk,
  input wire logic pin_out,
  input wire logic pin_oe_n,
  output logic pin_level
);
  // a released open-drain wire floats up to the pull-up level
  always_ff @(posedge aclk) begin
    pin_level <= pin_oe_n ? 1'b1 : pin_out;
  end
endmodule
`default_nettype wire

// ==== verif/nfc_frontend_interrupt_unit_test.sv ====
// self-checking bench for the interrupt request unit
// assumes the unit's axi4-lite slave and the host pin model
`timescale 1ns/1ps
`default_nettype none
`include "nfi_params.svh"
module nfc_frontend_interrupt_unit_test;
  import nfi_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam logic [7:0] A_F0 = {`NFI_IDX_FLAGS0, 2'b00};
  localparam logic [7:0] A_F1 = {`NFI_IDX_FLAGS1, 2'b00};
  localparam logic [7:0] A_E0 = {`NFI_IDX_EN0, 2'b00};
  localparam logic [7:0] A_E1 = {`NFI_IDX_EN1, 2'b00};
  localparam logic [7:0] A_CMD = {`NFI_IDX_CMD, 2'b00};
  localparam logic [7:0] A_PIN = {`NFI_IDX_PIN, 2'b00};
  logic aclk, aresetn, clk_en, cmd_end;
  logic [7:0] awaddr, araddr;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, cmd_code;
  logic [1:0] bresp, rresp, resp_q;
  logic pin_out, pin_oe_n, pin_level;
  nfi_events_type ev;
  logic [15:0] x;
  int bad_count, total_checks;

  nfi_irq_unit #(.CMD_W(4)) u_nfi_irq_unit (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .events(ev),
    .command_self_end(cmd_end), .command_code(cmd_code),
    .request_pin_out(pin_out), .request_pin_oe_n(pin_oe_n)
  );
  nfi_host_pin u_nfi_host_pin (
    .aclk(aclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_level(pin_level)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang;
    bad_count++;
    $display("[FAIL] %0t no answer from the unit", $time);
    results();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 40);
    bready <= 1'b0;
    if (n >= 40) hang();
    chk({30'h0, bresp}, {30'h0, `NFI_RESP_OKAY});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 40);
    rready <= 1'b0;
    resp_q = rresp;
    if (n >= 40) hang();
    chk(rdata, {24'h0, exp});
  endtask
  task automatic pulse(input nfi_events_type e);
    @(posedge aclk);
    ev <= e;
    @(posedge aclk);
    ev <= '0;
  endtask
  // expected level, drive value and enable of the pin
  task automatic pin_chk(input logic [2:0] exp);
    repeat (5) @(posedge aclk);
    chk({29'h0, pin_level, pin_out, pin_oe_n}, {29'h0, exp});
  endtask
  // register address and flag byte for one event input bit
  function automatic logic [15:0] ev_exp(input int i);
    logic [7:0] b;
    if (i >= 12) b = 8'h01 << ((i > 13) ? i - 9 : i - 10);
    else if (i >= 7) b = 8'h02;
    else if (i == 6) b = 8'h01;
    else b = 8'h01 << i;
    return {(i > 5) ? A_F0 : A_F1, b};
  endfunction
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    aresetn = 1'b0;
    clk_en = 1'b1;
    cmd_end = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    ev = '0;
    bad_count = 0;
    total_checks = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_F0, 8'h00);
    rd(A_F1, 8'h00);
    rd(8'h00, 8'h00);
    chk({30'h0, resp_q}, {30'h0, `NFI_RESP_DECERR});
    wr(A_F0, 8'hFF);
    rd(A_F0, 8'h7F);
    wr(A_F0, 8'h05);
    rd(A_F0, 8'h7A);
    wr(A_F0, 8'h7F);
    rd(A_F0, 8'h00);
    wr(A_F1, 8'hFF);
    rd(A_F1, 8'h3F);
    wr(A_F1, 8'h21);
    rd(A_F1, 8'h1E);
    wr(A_F1, 8'h7F);
    for (int i = 0; i < 16; i++) begin
      x = ev_exp(i);
      pulse(nfi_events_type'(16'h0001 << i));
      rd(x[15:8], x[7:0]);
      wr(x[15:8], 8'h7F);
    end
    // an event while the clock enable is low is not seen
    @(posedge aclk);
    clk_en <= 1'b0;
    pulse(nfi_events_type'(16'h0001));
    clk_en <= 1'b1;
    rd(A_F1, 8'h00);
    wr(A_CMD, 8'h03);
    chk({28'h0, cmd_code}, 32'h3);
    @(posedge aclk);
    cmd_end <= 1'b1;
    @(posedge aclk);
    cmd_end <= 1'b0;
    rd(A_F0, 8'h10);
    wr(A_F0, 8'h7F);
    wr(A_CMD, 8'h0F);
    repeat (2) @(posedge aclk);
    chk({28'h0, cmd_code}, 32'h0);
    rd(A_F0, 8'h10);
    wr(A_F0, 8'h7F);
    wr(A_CMD, 8'h02);
    wr(A_CMD, 8'h00);
    rd(A_F0, 8'h00);
    wr(A_E0, 8'h04);
    wr(A_E1, 8'h40);
    rd(A_E0, 8'h04);
    pulse(nfi_events_type'(16'h1000));
    rd(A_F1, 8'h40);
    pin_chk(3'b111);
    wr(A_E0, 8'h84);
    pin_chk(3'b000);
    wr(A_E1, 8'hC0);
    pin_chk(3'b000);
    wr(A_E0, 8'h04);
    pin_chk(3'b110);
    wr(A_E1, 8'h80);
    pin_chk(3'b000);
    wr(A_E0, 8'h00);
    rd(A_F1, 8'h00);
    rd(A_F0, 8'h04);
    wr(A_E1, 8'hE0);
    pulse(nfi_events_type'(16'h0020));
    rd(A_F1, 8'h60);
    pin_chk(3'b110);
    rd(A_PIN, 8'h01);
    wr(A_F1, 8'h7F);
    rd(A_F1, 8'h00);
    results();
  end
endmodule
`default_nettype wire
